// *** inc/ssc_pkg.sv ***
// constants and carrier types for the clock-synchronous serial channel
package ssc_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_TXBUF = 8'h00;
    localparam logic [7:0] OFS_RXBUF = 8'h04;
    localparam logic [7:0] OFS_BAUD  = 8'h08;
    localparam logic [7:0] OFS_MODE  = 8'h0C;
    localparam logic [7:0] OFS_CTL0  = 8'h10;
    localparam logic [7:0] OFS_CTL1  = 8'h14;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MODE_CLOCK_SOURCE_DIRECTION  = 3;  // mode_reg: [2:0] mode_field
    localparam int C0_VACANT   = 3;  // control0: [1:0] prescale_select
    localparam int C0_ODRAIN   = 5;
    localparam int C0_EDGE     = 6;
    localparam int C0_ORDER    = 7;
    localparam int C1_TXEN     = 0;
    localparam int C1_TXVAC    = 1;
    localparam int C1_RXALLOW  = 2;
    localparam int C1_RXDONE   = 3;
    localparam int C1_IRQSRC   = 4;
    localparam int C1_CONTRX   = 5;
    localparam int RB_OVERRUN  = 12; // rx_buffer_reg: [7:0] data
    localparam int RB_FRAMING  = 13;
    localparam int RB_PARITY   = 14;
    localparam int RB_SUM      = 15;

    // ------------------------------------------------------------
    // values, reset values and counts
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_OFF  = 3'h0;
    localparam logic [2:0] MODE_SYNC = 3'h1;
    localparam logic [1:0] PS_F1     = 2'h0;
    localparam logic [1:0] PS_F8     = 2'h1;
    localparam logic [4:0] DIV_F8    = 5'h07;
    localparam logic [4:0] DIV_F32   = 5'h1F;
    localparam logic [2:0] LAST_BIT  = 3'h7;
    localparam logic [2:0] OVR_BIT   = 3'h6;  // index of the 7th bit
    localparam logic [7:0] BAUD_RST  = 8'h00;

    // serial pin drive bundle
    typedef struct packed {
        logic so;        // serial_out_pin level
        logic so_oe_n;   // serial_out_pin enable, low drives
        logic ck;        // transfer_clock_pin level
        logic ck_oe_n;   // transfer_clock_pin enable, low drives
    } ssc_pins_s;

endpackage

// *** hdl/ssc_channel.sv ***
// one clock-synchronous serial channel with its classic Wishbone register slave
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/100ps
module ssc_channel #(
    parameter int DW = 8
) (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    // classic wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    // serial pins
    input  wire logic                  serial_in_pin,
    input  wire logic                  transfer_clock_pin_i,
    output ssc_pkg::ssc_pins_s         pins_o,
    // interrupt requests
    output logic                       tx_irq_o,
    output logic                       rx_irq_o
);

    typedef enum logic {SSC_IDLE, SSC_SHIFT} ssc_state_e;

    // --------------------------------------------------------
    // helpers
    // --------------------------------------------------------
    // position of the n-th transferred bit
    function automatic logic [2:0] ssc_bit_idx(input logic msb, input logic [2:0] n);
        ssc_bit_idx = msb ? (ssc_pkg::LAST_BIT - n) : n;
    endfunction

    // registers
    logic [DW-1:0] tx_buffer_r;
    logic [DW-1:0] rx_buffer_r;
    logic [7:0]    baud_divider_r;
    logic [2:0]    mode_field_r;
    logic          clock_source_direction_r;
    logic [1:0]    prescale_select_r;
    logic          open_drain_select_r;
    logic          clock_edge_select_r;
    logic          bit_order_select_r;
    logic          tx_enable_bit_r;
    logic          rx_allow_r;
    logic          tx_irq_source_select_r;
    logic          continuous_rx_select_r;
    logic          tx_buffer_vacant_r;
    logic          shift_reg_vacant_r;
    logic          rx_complete_flag_r;
    logic          overrun_flag_r;
    logic          parity_fault_r;
    logic          framing_fault_r;
    // engine
    ssc_state_e    state_r;
    logic [DW-1:0] tx_shift_r;
    logic [DW-1:0] rx_shift_r;
    logic [2:0]    bit_cnt_r;
    logic          rx_on_r;
    logic          so_bit_r;
    logic          int_clk_r;
    logic          int_toggled_r;
    logic [4:0]    pre_cnt_r;
    logic [7:0]    baud_cnt_r;
    logic [1:0]    si_sync_r;
    logic [1:0]    ck_sync_r;
    logic          ck_prev_r;

    // --------------------------------------------------------
    // bus decode
    // --------------------------------------------------------
    logic bus_req;
    logic wr_txbuf;
    logic wr_baud;
    logic wr_mode;
    logic wr_ctl0;
    logic wr_ctl1;
    logic rd_rxbuf;
    logic chan_on;
    logic err_clear;

    assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_txbuf  = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == ssc_pkg::OFS_TXBUF);
    assign wr_baud   = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == ssc_pkg::OFS_BAUD);
    assign wr_mode   = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == ssc_pkg::OFS_MODE);
    assign wr_ctl0   = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == ssc_pkg::OFS_CTL0);
    assign wr_ctl1   = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == ssc_pkg::OFS_CTL1);
    assign rd_rxbuf  = bus_req & ~wb_we_i & (wb_adr_i == ssc_pkg::OFS_RXBUF);
    assign chan_on   = (mode_field_r == ssc_pkg::MODE_SYNC);
    assign err_clear = (mode_field_r == ssc_pkg::MODE_OFF) | ~rx_allow_r;

    // --------------------------------------------------------
    // transfer clock timing
    // --------------------------------------------------------
    logic pre_tick;
    logic baud_tick;
    logic ck_lvl;
    logic ck_last;
    logic ck_moved;
    logic edge_rise;
    logic edge_fall;
    logic chg_edge;
    logic smp_edge;
    logic start_ok;
    logic word_done;
    logic reload;

    always_comb begin
        unique case (prescale_select_r)
            ssc_pkg::PS_F1: pre_tick = 1'b1;
            ssc_pkg::PS_F8: pre_tick = (pre_cnt_r[2:0] == ssc_pkg::DIV_F8[2:0]);
            default:        pre_tick = (pre_cnt_r == ssc_pkg::DIV_F32);
        endcase
    end

    assign baud_tick = pre_tick & (baud_cnt_r == 8'h00);
    assign ck_lvl    = clock_source_direction_r ? ck_sync_r[1] : int_clk_r;
    assign ck_last   = clock_source_direction_r ? ck_prev_r : ~int_clk_r;
    assign ck_moved  = clock_source_direction_r | int_toggled_r;  // internal edge only on toggle
    assign edge_rise = (state_r == SSC_SHIFT) & ck_lvl & ~ck_last & ck_moved;
    assign edge_fall = (state_r == SSC_SHIFT) & ~ck_lvl & ck_last & ck_moved;
    assign chg_edge  = clock_edge_select_r ? edge_rise : edge_fall;
    assign smp_edge  = clock_edge_select_r ? edge_fall : edge_rise;
    assign start_ok  = chan_on & tx_enable_bit_r & ~tx_buffer_vacant_r;
    assign word_done = smp_edge & (bit_cnt_r == ssc_pkg::LAST_BIT);
    assign reload    = word_done & start_ok;

    // prescaler f1 / f8 / f32
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_cnt_r <= 5'h00;
        end else if (pre_tick) begin
            pre_cnt_r <= 5'h00;
        end else begin
            pre_cnt_r <= pre_cnt_r + 5'h01;
        end
    end

    // per-channel baud timer, half period of n+1 source ticks
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            baud_cnt_r    <= ssc_pkg::BAUD_RST;
            int_clk_r     <= 1'b1;
            int_toggled_r <= 1'b0;
        end else begin
            int_toggled_r <= 1'b0;
            if (state_r != SSC_SHIFT) begin
                baud_cnt_r <= baud_divider_r;
                int_clk_r  <= ~clock_edge_select_r;
            end else if (baud_tick) begin
                baud_cnt_r    <= baud_divider_r;
                int_clk_r     <= ~int_clk_r;
                int_toggled_r <= 1'b1;
            end else if (pre_tick) begin
                baud_cnt_r <= baud_cnt_r - 8'h01;
            end
        end
    end

    // pin synchronisers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            si_sync_r <= 2'h3;
            ck_sync_r <= 2'h3;
            ck_prev_r <= 1'b1;
        end else begin
            si_sync_r <= {si_sync_r[0], serial_in_pin};
            ck_sync_r <= {ck_sync_r[0], transfer_clock_pin_i};
            ck_prev_r <= ck_sync_r[1];
        end
    end

    // --------------------------------------------------------
    // shift engine
    // --------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r            <= SSC_IDLE;
            tx_shift_r         <= '0;
            rx_shift_r         <= '0;
            bit_cnt_r          <= 3'h0;
            rx_on_r            <= 1'b0;
            so_bit_r           <= 1'b1;
            shift_reg_vacant_r <= 1'b1;
        end else if (!chan_on) begin
            state_r            <= SSC_IDLE;
            so_bit_r           <= 1'b1;
            shift_reg_vacant_r <= 1'b1;
        end else begin
            unique case (state_r)
                SSC_IDLE: begin
                    if (start_ok) begin
                        state_r            <= SSC_SHIFT;
                        tx_shift_r         <= tx_buffer_r;
                        rx_on_r            <= rx_allow_r;
                        bit_cnt_r          <= 3'h0;
                        shift_reg_vacant_r <= 1'b0;
                    end
                end
                SSC_SHIFT: begin
                    if (chg_edge) begin
                        so_bit_r <= tx_shift_r[ssc_bit_idx(bit_order_select_r, bit_cnt_r)];
                    end
                    if (smp_edge) begin
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        if (bit_order_select_r) begin
                            rx_shift_r <= {rx_shift_r[DW-2:0], si_sync_r[1]};
                        end else begin
                            rx_shift_r <= {si_sync_r[1], rx_shift_r[DW-1:1]};
                        end
                    end
                    if (reload) begin
                        tx_shift_r <= tx_buffer_r;
                        rx_on_r    <= rx_allow_r;
                        bit_cnt_r  <= 3'h0;
                    end else if (word_done) begin
                        state_r            <= SSC_IDLE;
                        shift_reg_vacant_r <= 1'b1;
                    end
                end
            endcase
        end
    end

    // received word as it completes
    logic [DW-1:0] rx_word;
    logic          rx_move;
    logic          ovr_hit;

    assign rx_word = bit_order_select_r ? {rx_shift_r[DW-2:0], si_sync_r[1]}
                                        : {si_sync_r[1], rx_shift_r[DW-1:1]};
    assign rx_move = word_done & rx_on_r;
    assign ovr_hit = smp_edge & rx_on_r & (bit_cnt_r == ssc_pkg::OVR_BIT)
                   & rx_complete_flag_r & ~rd_rxbuf;

    // --------------------------------------------------------
    // status flags
    // --------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_buffer_vacant_r <= 1'b1;
        end else if (wr_txbuf || (rd_rxbuf && continuous_rx_select_r)) begin
            tx_buffer_vacant_r <= 1'b0;
        end else if ((state_r == SSC_IDLE && start_ok) || reload) begin
            tx_buffer_vacant_r <= 1'b1;
        end
    end

    // receive buffer and complete flag, set wins over read
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_buffer_r        <= '0;
            rx_complete_flag_r <= 1'b0;
        end else begin
            if (rx_move) begin
                rx_buffer_r        <= rx_word;
                rx_complete_flag_r <= 1'b1;
            end else if (rd_rxbuf) begin
                rx_complete_flag_r <= 1'b0;
            end
        end
    end

    // error flags
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            overrun_flag_r  <= 1'b0;
            parity_fault_r  <= 1'b0;
            framing_fault_r <= 1'b0;
        end else if (err_clear) begin
            overrun_flag_r  <= 1'b0;
            parity_fault_r  <= 1'b0;
            framing_fault_r <= 1'b0;
        end else begin
            if (ovr_hit) begin
                overrun_flag_r <= 1'b1;
            end
            if (rd_rxbuf && wb_sel_i[1]) begin
                parity_fault_r  <= 1'b0;
                framing_fault_r <= 1'b0;
            end
        end
    end

    // interrupt request pulses
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_irq_o <= 1'b0;
            rx_irq_o <= 1'b0;
        end else begin
            tx_irq_o <= tx_irq_source_select_r ? (word_done & ~reload)
                        : ((state_r == SSC_IDLE && chan_on && start_ok) || reload);
            rx_irq_o <= rx_move & ~overrun_flag_r & ~ovr_hit;
        end
    end

    // pin drive, registered
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pins_o <= '{so: 1'b1, so_oe_n: 1'b0, ck: 1'b1, ck_oe_n: 1'b1};
        end else begin
            pins_o.so      <= open_drain_select_r ? 1'b0 : so_bit_r;
            pins_o.so_oe_n <= open_drain_select_r ? so_bit_r : 1'b0;
            pins_o.ck      <= int_clk_r;
            pins_o.ck_oe_n <= clock_source_direction_r | ~chan_on;
        end
    end

    // --------------------------------------------------------
    // control registers
    // --------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_buffer_r              <= '0;
            baud_divider_r           <= ssc_pkg::BAUD_RST;
            mode_field_r             <= ssc_pkg::MODE_OFF;
            clock_source_direction_r <= 1'b0;
            prescale_select_r        <= ssc_pkg::PS_F1;
            open_drain_select_r      <= 1'b0;
            clock_edge_select_r      <= 1'b0;
            bit_order_select_r       <= 1'b0;
            tx_enable_bit_r          <= 1'b0;
            rx_allow_r               <= 1'b0;
            tx_irq_source_select_r   <= 1'b0;
            continuous_rx_select_r   <= 1'b0;
        end else begin
            if (wr_txbuf) begin
                tx_buffer_r <= wb_dat_i[DW-1:0];
            end
            if (wr_baud) begin
                baud_divider_r <= wb_dat_i[7:0];
            end
            if (wr_mode) begin
                mode_field_r             <= wb_dat_i[2:0];
                clock_source_direction_r <= wb_dat_i[ssc_pkg::MODE_CLOCK_SOURCE_DIRECTION];
            end
            if (wr_ctl0) begin
                prescale_select_r   <= wb_dat_i[1:0];
                open_drain_select_r <= wb_dat_i[ssc_pkg::C0_ODRAIN];
                clock_edge_select_r <= wb_dat_i[ssc_pkg::C0_EDGE];
                bit_order_select_r  <= wb_dat_i[ssc_pkg::C0_ORDER];
            end
            if (wr_ctl1) begin
                tx_enable_bit_r        <= wb_dat_i[ssc_pkg::C1_TXEN];
                rx_allow_r             <= wb_dat_i[ssc_pkg::C1_RXALLOW];
                tx_irq_source_select_r <= wb_dat_i[ssc_pkg::C1_IRQSRC];
                continuous_rx_select_r <= wb_dat_i[ssc_pkg::C1_CONTRX];
            end
        end
    end

    // --------------------------------------------------------
    // read mux and ack
    // --------------------------------------------------------
    logic [31:0] rd_data;

    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (wb_adr_i)
            ssc_pkg::OFS_RXBUF: begin
                rd_data[DW-1:0]            = rx_buffer_r;
                rd_data[ssc_pkg::RB_OVERRUN] = overrun_flag_r;
                rd_data[ssc_pkg::RB_FRAMING] = framing_fault_r;
                rd_data[ssc_pkg::RB_PARITY]  = parity_fault_r;
                rd_data[ssc_pkg::RB_SUM]     = overrun_flag_r | framing_fault_r
                                             | parity_fault_r;
            end
            ssc_pkg::OFS_MODE: begin
                rd_data[2:0]                 = mode_field_r;
                rd_data[ssc_pkg::MODE_CLOCK_SOURCE_DIRECTION] = clock_source_direction_r;
            end
            ssc_pkg::OFS_CTL0: begin
                rd_data[1:0]                = prescale_select_r;
                rd_data[ssc_pkg::C0_VACANT] = shift_reg_vacant_r;
                rd_data[ssc_pkg::C0_ODRAIN] = open_drain_select_r;
                rd_data[ssc_pkg::C0_EDGE]   = clock_edge_select_r;
                rd_data[ssc_pkg::C0_ORDER]  = bit_order_select_r;
            end
            ssc_pkg::OFS_CTL1: begin
                rd_data[ssc_pkg::C1_TXEN]    = tx_enable_bit_r;
                rd_data[ssc_pkg::C1_TXVAC]   = tx_buffer_vacant_r;
                rd_data[ssc_pkg::C1_RXALLOW] = rx_allow_r;
                rd_data[ssc_pkg::C1_RXDONE]  = rx_complete_flag_r;
                rd_data[ssc_pkg::C1_IRQSRC]  = tx_irq_source_select_r;
                rd_data[ssc_pkg::C1_CONTRX]  = continuous_rx_select_r;
            end
            default: rd_data = 32'h0000_0000;  // write-only and unmapped
        endcase
    end

    // one wait state, ack for one cycle
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_data : 32'h0000_0000;
        end
    end

endmodule

// *** verification/ssc_channel_sva.sv ***
// port assertions for the serial channel
`timescale 1ns/100ps
module ssc_channel_sva (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        reset_n,
    // register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // requests
    input wire logic        tx_irq_o,
    input wire logic        rx_irq_o
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // a read taken at this edge
    sequence s_rd(a);
        wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i == a && !wb_ack_o;
    endsequence
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data off ack");
    a_tx_pulse: assert property (tx_irq_o |=> !tx_irq_o) else $error("tx request long");
    a_rx_pulse: assert property (rx_irq_o |=> !rx_irq_o) else $error("rx request long");
    a_unmapped_zero: assert property (s_rd(8'h18) |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_sum_or:
        assert property (s_rd(ssc_pkg::OFS_RXBUF) |=> wb_dat_o[15] == |wb_dat_o[14:12])
        else $error("sum flag wrong");
    a_ctl_upper: assert property (s_rd(ssc_pkg::OFS_CTL1) |=> wb_dat_o[31:6] == 26'h0)
        else $error("control upper bits set");
endmodule
bind ssc_channel ssc_channel_sva chk_u (.core_clk, .reset_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .tx_irq_o, .rx_irq_o);

// *** verification/ssc_peer.sv ***
// behavioural clocked serial peer
`timescale 1ns/100ps
module ssc_peer (
    // bench control
    input  wire logic         arm,
    input  wire logic         go,
    input  wire logic         ext,
    input  wire logic         pol,
    input  wire logic         msb,
    input  wire logic [7:0]   word,
    // pins
    input  ssc_pkg::ssc_pins_s pins,
    output logic              sin,
    output logic              xck,
    output logic [7:0]        got,
    output logic [3:0]        cnt
);
    // device sample edge always seen as a rising edge here
    wire logic ck = (ext ? xck : pins.ck) ^ pol;
    // released open-drain output reads as the pull-up level
    wire logic so = pins.so_oe_n ? 1'b1 : pins.so;
    // external clock, still between frames, idle high
    initial begin
        xck = 1'b1;
        forever begin
            @(posedge go);
            #1;
            repeat (16) #25 xck = ~xck;
        end
    end
    // capture on rising edge
    always @(posedge ck or posedge arm)
        if (arm) cnt <= 4'h0;
        else if (cnt < 4'h8) begin
            got[msb ? 3'h7 - cnt[2:0] : cnt[2:0]] <= so;
            cnt <= cnt + 4'h1;
        end
    // next bit on falling edge, toggles once the word is over
    always @(negedge ck or posedge arm)
        if (arm) sin <= word[msb ? 7 : 0];
        else sin <= cnt < 4'h8 ? word[msb ? 3'h7 - cnt[2:0] : cnt[2:0]] : ~sin;
endmodule

// *** verification/ssc_channel_test.sv ***
// self-checking bench for the serial channel
`timescale 1ns/100ps
module ssc_channel_test;
    logic               core_clk, reset_n, cyc, stb, we, arm, go, ext, msb, pol;
    logic               ack, txi, rxi, sin, xck;
    logic [7:0]         adr, word, got;
    logic [31:0]        dat, dout, q;
    logic [3:0]         cnt;
    ssc_pkg::ssc_pins_s pins;
    int                 mismatches = 0, compares = 0, cyc_n = 0, tx_t, rx_t, rx_n = 0;
    ssc_channel dut_u (.core_clk, .reset_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
        .serial_in_pin(sin), .transfer_clock_pin_i(xck), .pins_o(pins), .tx_irq_o(txi),
        .rx_irq_o(rxi));
    ssc_peer peer_u (.arm, .go, .ext, .pol, .msb, .word, .pins, .sin, .xck, .got, .cnt);
    // clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // request timestamps
    always @(posedge core_clk) begin
        cyc_n <= cyc_n + 1;
        if (txi) tx_t <= cyc_n;
        if (rxi) rx_t <= cyc_n;
        if (rxi) rx_n <= rx_n + 1;
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one classic bus cycle, read data left in q
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge core_clk);
        end while (ack !== 1'b1);
        q = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic finish_test;
        if (mismatches == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // one word each way
    task automatic frame(input logic [7:0] c0, c1, tx, rx, input logic xo);
        int n;
        ext = xo;
        msb = c0[ssc_pkg::C0_ORDER];
        word = rx;
        arm = 1'b1;
        pol = c0[ssc_pkg::C0_EDGE];
        wb(1'b1, ssc_pkg::OFS_MODE, {28'h0, xo, ssc_pkg::MODE_SYNC});
        wb(1'b1, ssc_pkg::OFS_CTL0, {24'h0, c0});
        wb(1'b1, ssc_pkg::OFS_BAUD, 32'h7);
        wb(1'b1, ssc_pkg::OFS_CTL1, {24'h0, c1});
        arm = 1'b0;
        wb(1'b1, ssc_pkg::OFS_TXBUF, {24'h0, tx});
        repeat (10) @(posedge core_clk);
        go = xo;
        for (n = 0; n < 400 && cnt !== 4'h8; n++) @(posedge core_clk);
        repeat (20) @(posedge core_clk);
        go = 1'b0;
        chk("peer word", {24'h0, got}, {24'h0, tx});
    endtask
    // watchdog
    initial begin
        repeat (5000) @(posedge core_clk);
        mismatches++;
        finish_test;
    end
    initial begin
        {cyc, stb, we, adr, dat, arm, go, ext, msb, pol, word} = '0;
        reset_n = 1'b0;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        wb(1'b0, 8'h18, 32'h0);
        chk("unmapped", q, 32'h0);
        chk("so idle", {30'h0, pins.so, pins.so_oe_n}, 32'h2);
        // lsb first, request at buffer load
        frame(8'h00, 8'h05, 8'hA5, 8'h3C, 1'b0);
        chk("frame span", 32'(rx_t - tx_t > 120 && rx_t - tx_t < 140), 32'h1);
        chk("ck driven", pins.ck_oe_n, 1'b0);
        wb(1'b0, ssc_pkg::OFS_RXBUF, 32'h0);
        chk("rx data", q, 32'h3C);
        // msb first, swapped edges, open-drain, request at end of shift
        frame(8'hE0, 8'h15, 8'h4D, 8'hB2, 1'b0);
        chk("tx at end", 32'(rx_t - tx_t < 5 && tx_t - rx_t < 5), 32'h1);
        wb(1'b0, ssc_pkg::OFS_CTL0, 32'h0);
        chk("shift vacant", q[3], 1'b1);
        wb(1'b0, ssc_pkg::OFS_CTL1, 32'h0);
        chk("ctl1 flags", q[3:0], 4'hF);
        // external clock, buffer left unread
        frame(8'h00, 8'h05, 8'h96, 8'h5A, 1'b1);
        chk("no rx request", rx_n, 2);
        chk("ck input", pins.ck_oe_n, 1'b1);
        wb(1'b0, ssc_pkg::OFS_RXBUF, 32'h0);
        chk("overrun", q[15:12], 4'h9);
        wb(1'b1, ssc_pkg::OFS_CTL1, 32'h01);
        wb(1'b0, ssc_pkg::OFS_RXBUF, 32'h0);
        chk("flags cleared", q[15:12], 4'h0);
        // continuous receive, buffer read marks transmit data present
        wb(1'b1, ssc_pkg::OFS_CTL1, 32'h24);
        wb(1'b0, ssc_pkg::OFS_RXBUF, 32'h0);
        wb(1'b0, ssc_pkg::OFS_CTL1, 32'h0);
        chk("tx vacant", q[1], 1'b0);
        wb(1'b0, ssc_pkg::OFS_MODE, 32'h0);
        chk("mode", q, 32'h9);
        finish_test;
    end
endmodule
